// file: hdl/agf_pkg.sv
// agf_pkg: constants, types and helpers of the gain, offset and output formatter
package agf_pkg;

    // ==========================================================
    // sample path geometry
    localparam int SAMPLE_W = 14;
    localparam int PAIR_N = 7;
    localparam int LATENCY_CYCLES = 21;
    localparam int FRONT_STAGES = 4;
    localparam int DELAY_DEPTH = LATENCY_CYCLES - FRONT_STAGES;
    localparam int GAIN_FRAC = 12;
    localparam int ACC_W = 48;
    localparam int EST_W = 8;

    // ==========================================================
    // offset loop, codes and reset values
    localparam logic [4:0] TC_BASE_LOG2 = 5'h14;
    localparam logic [3:0] TC_LAST_CODE = 4'hB;
    localparam logic [3:0] TC_RESET_CODE = 4'h0;
    localparam logic [2:0] GAIN_RESET = 3'h0;
    localparam logic [3:0] SWING_RESET = 4'h0;
    // ten millivolts at 1.5 Vpp over 16384 codes
    localparam logic signed [ACC_W-1:0] OFS_LIMIT = 48'sh6D;
    localparam logic [SAMPLE_W-1:0] POS_FS = 14'h1FFF;
    localparam logic [SAMPLE_W-1:0] NEG_FS = 14'h2000;
    localparam logic [SAMPLE_W-1:0] OFFBIN_FLIP = 14'h2000;
    localparam logic [1:0] STRAP_TWOS_DDR = 2'h0;
    localparam logic [1:0] STRAP_OFFB_DDR = 2'h3;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [2:0] gain;
        logic loop_enable;
        logic [3:0] tc_code;
        logic loop_hold;
        logic use_strap;
        logic ddr_sel;
        logic offbin_sel;
        logic [3:0] swing;
        logic data_double;
        logic clock_double;
    } agf_cfg_t;

    typedef struct packed {
        logic ddr;
        logic offbin;
    } agf_mode_t;

    typedef struct packed {
        agf_cfg_t cfg;
        logic req;
        logic [1:0] ack_sync;
        logic busy;
    } agf_ctl_t;

    typedef struct packed {
        logic [1:0] req_sync;
        logic req_seen;
        logic ack;
        agf_cfg_t cfg;
        logic [1:0][1:0] strap_sync;
        logic [4:0] shift;
        logic [SAMPLE_W-1:0] cap;
        logic [15:0] gained;
        logic [SAMPLE_W-1:0] corr;
        logic [SAMPLE_W-1:0] fmt;
        logic [DELAY_DEPTH-1:0][SAMPLE_W-1:0] dly;
        logic [ACC_W-1:0] acc;
        logic [EST_W-1:0] est;
        logic [SAMPLE_W-1:0] par;
        logic [3:0] swing;
        logic data_double;
        logic clock_double;
    } agf_smp_t;

    localparam agf_cfg_t CFG_RESET = '{gain: GAIN_RESET, loop_enable: 1'b0,
        tc_code: TC_RESET_CODE, loop_hold: 1'b0, use_strap: 1'b1, ddr_sel: 1'b1,
        offbin_sel: 1'b0, swing: SWING_RESET, data_double: 1'b0, clock_double: 1'b0};

    // ==========================================================
    // helpers
    // gain in Q12, one entry per half decibel
    function automatic logic [13:0] gain_coef(input logic [2:0] code);
        unique case (code)
            3'h0: gain_coef = 14'h1000;
            3'h1: gain_coef = 14'h10F3;
            3'h2: gain_coef = 14'h11F4;
            3'h3: gain_coef = 14'h1304;
            3'h4: gain_coef = 14'h1425;
            3'h5: gain_coef = 14'h1556;
            3'h6: gain_coef = 14'h169A;
            3'h7: gain_coef = 14'h17F1;
        endcase
    endfunction : gain_coef

    // loop time constant is two to the power of this shift
    function automatic logic [4:0] tc_shift(input logic [3:0] code);
        tc_shift = TC_BASE_LOG2 + {1'b0, code};
    endfunction : tc_shift

    function automatic agf_mode_t strap_mode(input logic [1:0] strap);
        strap_mode.ddr = (strap == STRAP_TWOS_DDR) || (strap == STRAP_OFFB_DDR);
        strap_mode.offbin = strap[1];
    endfunction : strap_mode

endpackage : agf_pkg

// file: hdl/agf_ddr_out.sv
// agf_ddr_out: double data rate output cell, one bit per clock half
`timescale 1ns/1ps
`default_nettype none

module agf_ddr_out #(
    parameter bit RST_VAL = 1'b0
) (
    // clock and reset of the sampling domain
    input wire logic clk_i,
    input wire logic rst_i,
    // data for the high and the low half of the next period
    input wire logic rise_i,
    input wire logic fall_i,
    // pin
    output logic q_o
);

    // ==========================================================
    // capture both halves on the rising edge
    logic rise_q;
    logic fall_pre_q;
    logic fall_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_q <= RST_VAL;
            fall_pre_q <= RST_VAL;
        end else begin
            rise_q <= rise_i;
            fall_pre_q <= fall_i;
        end
    end

    // low half is relaunched on the falling edge so it cannot glitch early
    always_ff @(negedge clk_i) begin
        if (rst_i) begin
            fall_q <= RST_VAL;
        end else begin
            fall_q <= fall_pre_q;
        end
    end

    // clock steers the pin mux, as a hard output cell would
    assign q_o = clk_i ? rise_q : fall_q;

endmodule : agf_ddr_out

`default_nettype wire

// file: hdl/agf_formatter.sv
// agf_formatter: gain, dc offset loop and ddr or parallel output formatter
`timescale 1ns/1ps
`default_nettype none

// How it works
// - gain code picks zero to 3.5 dB in half decibel steps.
// - higher gain shrinks full scale, 1.5 Vpp down to 1 Vpp.
// - reset leaves gain at zero decibel until a new code arrives.
// - offset estimate is clamped to about ten millivolts either way.
// - loop enabled: estimate updates and correction applies every sample.
// - time constant code gives 2^(20+code) cycles, codes above 1011 reserved.
// - hold stops estimate updates but keeps applying the last estimate.
// - reset leaves the offset loop off until software enables it.
// - 14 or 12 bit words leave with an aligned forwarded clock.
// - ddr or parallel output chosen by select bit or by strap.
// - ddr mode carries two sample bits per pair each sample period.
// - even bits launch on forwarded clock fall, odd bits on rise.
// - swing field passes to the pair drivers, zero means nominal.
// - separate drive doubling for data and clock pairs, off after reset.
// - parallel mode puts each bit on its own pin, one word per cycle.
// - sample reaches the pins 21 sampling cycles after capture.
// - words are offset binary or twos complement by bit or strap.
// - overload saturates to full scale codes of the chosen format.

module agf_formatter import agf_pkg::*; #(
    parameter bit VARIANT_12BIT = 1'b0
) (
    // control clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // configuration levels, control domain
    input wire logic [2:0] gain_code_i,
    input wire logic offset_loop_enable_i,
    input wire logic [3:0] offset_loop_tc_code_i,
    input wire logic offset_loop_hold_i,
    input wire logic use_strap_i,
    input wire logic ddr_select_i,
    input wire logic offset_binary_i,
    input wire logic [3:0] lvds_swing_i,
    input wire logic data_pair_drive_double_i,
    input wire logic clock_pair_drive_double_i,
    // control status
    output logic cfg_busy_o,
    // strap pin, asynchronous
    input wire logic [1:0] format_interface_strap_i,
    // conversion pipeline, sampling domain
    input wire logic smp_clk_i,
    input wire logic [SAMPLE_W-1:0] conv_sample_i,
    // output pins
    output logic [SAMPLE_W-1:0] par_data_o,
    output logic [PAIR_N-1:0] pair_pos_o,
    output logic [PAIR_N-1:0] pair_neg_o,
    output logic forwarded_clock_pos_o,
    output logic forwarded_clock_neg_o,
    // pad driver settings and loop status, sampling domain
    output logic [3:0] lvds_swing_o,
    output logic data_pair_drive_double_o,
    output logic clock_pair_drive_double_o,
    output logic [EST_W-1:0] offset_estimate_o
);

    // ==========================================================
    // helpers
    function automatic logic [SAMPLE_W-1:0] sat14(input logic signed [17:0] v);
        if (v > $signed({4'h0, POS_FS})) begin
            sat14 = POS_FS;
        end else if (v < $signed({4'hF, NEG_FS})) begin
            sat14 = NEG_FS;
        end else begin
            sat14 = v[SAMPLE_W-1:0];
        end
    endfunction : sat14

    function automatic logic [EST_W-1:0] clamp_est(input logic signed [ACC_W-1:0] v);
        if (v > OFS_LIMIT) begin
            clamp_est = OFS_LIMIT[EST_W-1:0];
        end else if (v < -OFS_LIMIT) begin
            clamp_est = EST_W'(-OFS_LIMIT);
        end else begin
            clamp_est = v[EST_W-1:0];
        end
    endfunction : clamp_est

    // ==========================================================
    // control domain: configuration launch by toggle handshake
    agf_ctl_t ctl_q;
    agf_ctl_t ctl_d;
    agf_smp_t s_q;
    agf_smp_t s_d;
    agf_cfg_t cfg_in;
    logic ctl_idle;

    // gather the level ports into one word for the crossing
    always_comb begin
        cfg_in.gain = gain_code_i;
        cfg_in.loop_enable = offset_loop_enable_i;
        cfg_in.tc_code = offset_loop_tc_code_i;
        cfg_in.loop_hold = offset_loop_hold_i;
        cfg_in.use_strap = use_strap_i;
        cfg_in.ddr_sel = ddr_select_i;
        cfg_in.offbin_sel = offset_binary_i;
        cfg_in.swing = lvds_swing_i;
        cfg_in.data_double = data_pair_drive_double_i;
        cfg_in.clock_double = clock_pair_drive_double_i;
    end

    // held word stays still while a request is open, so the far side reads it safely
    always_comb begin
        ctl_d = ctl_q;
        ctl_d.ack_sync = {ctl_q.ack_sync[0], s_q.ack};
        ctl_idle = (ctl_q.req == ctl_q.ack_sync[1]);
        if (ctl_idle && (cfg_in != ctl_q.cfg)) begin
            ctl_d.cfg = cfg_in;
            ctl_d.req = ~ctl_q.req;
        end
        ctl_d.busy = (ctl_d.req != ctl_d.ack_sync[1]) || (cfg_in != ctl_d.cfg);
    end

    // defaults hold gain at zero decibel and the loop off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= '{cfg: CFG_RESET, req: 1'b0, ack_sync: 2'h0, busy: 1'b0};
        end else begin
            ctl_q <= ctl_d;
        end
    end

    assign cfg_busy_o = ctl_q.busy;

    // ==========================================================
    // sampling domain reset, synchronised from the control reset
    logic [1:0] srst_q;
    logic smp_rst;

    // no reset of its own; rst_i must be held across three sampling periods
    always_ff @(posedge smp_clk_i) begin
        srst_q <= {srst_q[0], rst_i};
    end

    assign smp_rst = srst_q[1];

    // ==========================================================
    // sampling domain datapath
    agf_mode_t mode;
    logic signed [28:0] prod;
    logic signed [17:0] diff;
    logic signed [ACC_W-1:0] est_raw;
    logic signed [ACC_W-1:0] corr_ext;
    logic windup;
    logic [SAMPLE_W-1:0] word;
    logic [SAMPLE_W-1:0] last;

    always_comb begin
        s_d = s_q;

        // configuration arrives when the request toggle is seen
        s_d.req_sync = {s_q.req_sync[0], ctl_q.req};
        s_d.req_seen = s_q.req_sync[1];
        if (s_q.req_sync[1] != s_q.req_seen) begin
            s_d.cfg = ctl_q.cfg;
            s_d.ack = s_q.req_sync[1];
        end

        // strap pin is synchronised before anything decodes it, both bits per stage
        s_d.strap_sync = {s_q.strap_sync[0], format_interface_strap_i};
        if (s_q.cfg.use_strap) begin
            mode = strap_mode(s_q.strap_sync[1]);
        end else begin
            mode = '{ddr: s_q.cfg.ddr_sel, offbin: s_q.cfg.offbin_sel};
        end

        // a reserved code keeps the previous shift
        if (s_q.cfg.tc_code <= TC_LAST_CODE) begin
            s_d.shift = tc_shift(s_q.cfg.tc_code);
        end

        // stage one: capture the converter word
        s_d.cap = conv_sample_i;

        // stage two: digital gain, narrows the usable full scale
        prod = $signed(s_q.cap) * $signed({1'b0, gain_coef(s_q.cfg.gain)});
        s_d.gained = prod[GAIN_FRAC+15:GAIN_FRAC];

        // stage three: subtract the estimate, then saturate on overload
        diff = $signed({{2{s_q.gained[15]}}, s_q.gained})
            - $signed({{(18-EST_W){s_q.est[EST_W-1]}}, s_q.est});
        s_d.corr = sat14(diff);

        // offset loop: first order accumulator on the corrected output
        corr_ext = $signed({{(ACC_W-SAMPLE_W){s_q.corr[SAMPLE_W-1]}}, s_q.corr});
        est_raw = $signed(s_q.acc) >>> s_q.shift;
        // stop integrating further into the clamp so release is quick
        windup = ((est_raw >= OFS_LIMIT) && !corr_ext[ACC_W-1] && (corr_ext != '0))
            || ((est_raw <= -OFS_LIMIT) && corr_ext[ACC_W-1]);
        if (!s_q.cfg.loop_enable) begin
            s_d.acc = '0;
            s_d.est = '0;
        end else begin
            if (!s_q.cfg.loop_hold && !windup) begin
                s_d.acc = ACC_W'($signed(s_q.acc) + corr_ext);
            end
            s_d.est = clamp_est(est_raw);
        end

        // stage four: output coding
        word = mode.offbin ? (s_q.corr ^ OFFBIN_FLIP) : s_q.corr;
        if (VARIANT_12BIT) begin
            word = {2'h0, word[SAMPLE_W-1:2]};
        end
        s_d.fmt = word;

        // pad the pipe so the word reaches the pins at the fixed latency
        s_d.dly = {s_q.dly[DELAY_DEPTH-2:0], s_q.fmt};
        last = s_q.dly[DELAY_DEPTH-1];

        // parallel pins hold still in ddr mode to save switching noise
        s_d.par = mode.ddr ? '0 : last;

        // pad driver settings follow the configuration
        s_d.swing = s_q.cfg.swing;
        s_d.data_double = s_q.cfg.data_double;
        s_d.clock_double = s_q.cfg.clock_double;
    end

    always_ff @(posedge smp_clk_i) begin
        if (smp_rst) begin
            s_q <= '0;
            s_q.cfg <= CFG_RESET;
            s_q.shift <= tc_shift(TC_RESET_CODE);
        end else begin
            s_q <= s_d;
        end
    end

    assign par_data_o = s_q.par;
    assign lvds_swing_o = s_q.swing;
    assign data_pair_drive_double_o = s_q.data_double;
    assign clock_pair_drive_double_o = s_q.clock_double;
    assign offset_estimate_o = s_q.est;

    // ==========================================================
    // ddr pins; the cells register the word of stage 21 themselves
    logic [SAMPLE_W-1:0] ddr_word;
    logic clk_rise;
    logic clk_fall;

    // pairs idle low in parallel mode
    assign ddr_word = mode.ddr ? last : '0;

    // ddr: clock follows the sampling clock; parallel: clock inverted, rise mid-word
    assign clk_rise = mode.ddr;
    assign clk_fall = ~mode.ddr;

    genvar gi;
    generate
        for (gi = 0; gi < PAIR_N; gi++) begin : g_pair
            // odd bit in the high half, even bit after the fall
            agf_ddr_out #(.RST_VAL(1'b0)) u_pos (
                .clk_i(smp_clk_i),
                .rst_i(smp_rst),
                .rise_i(ddr_word[2*gi+1]),
                .fall_i(ddr_word[2*gi]),
                .q_o(pair_pos_o[gi])
            );
            agf_ddr_out #(.RST_VAL(1'b1)) u_neg (
                .clk_i(smp_clk_i),
                .rst_i(smp_rst),
                .rise_i(~ddr_word[2*gi+1]),
                .fall_i(~ddr_word[2*gi]),
                .q_o(pair_neg_o[gi])
            );
        end
    endgenerate

    agf_ddr_out #(.RST_VAL(1'b0)) u_clk_pos (
        .clk_i(smp_clk_i),
        .rst_i(smp_rst),
        .rise_i(clk_rise),
        .fall_i(clk_fall),
        .q_o(forwarded_clock_pos_o)
    );

    agf_ddr_out #(.RST_VAL(1'b1)) u_clk_neg (
        .clk_i(smp_clk_i),
        .rst_i(smp_rst),
        .rise_i(~clk_rise),
        .fall_i(~clk_fall),
        .q_o(forwarded_clock_neg_o)
    );

endmodule : agf_formatter

`default_nettype wire

// file: tb/agf_formatter_checker.sv
// agf_formatter_checker: concurrent checks on the formatter pins
`timescale 1ns/1ps
`default_nettype none

module agf_formatter_checker import agf_pkg::*; (
    // clocks and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic smp_clk_i,
    // control side
    input wire logic [2:0] gain_code_i,
    input wire logic cfg_busy_o,
    // output pins
    input wire logic [SAMPLE_W-1:0] par_data_o,
    input wire logic [PAIR_N-1:0] pair_pos_o,
    input wire logic [PAIR_N-1:0] pair_neg_o,
    input wire logic forwarded_clock_pos_o,
    input wire logic forwarded_clock_neg_o,
    input wire logic [EST_W-1:0] offset_estimate_o
);
    // ==========================================================
    // legs of each pair stay complementary
    pair_compl_a: assert property (@(posedge smp_clk_i) disable iff (rst_i)
        pair_neg_o == ~pair_pos_o) else $error("pair legs not complementary");
    clk_compl_a: assert property (@(posedge smp_clk_i) disable iff (rst_i)
        forwarded_clock_neg_o != forwarded_clock_pos_o) else $error("clock legs equal");

    // ==========================================================
    // clock seen before a sampling edge: low in ddr mode, high in parallel
    par_idle_a: assert property (@(posedge smp_clk_i) disable iff (rst_i)
        !forwarded_clock_pos_o && !$past(forwarded_clock_pos_o) |-> par_data_o == '0)
        else $error("parallel bus active in ddr mode");
    pair_idle_a: assert property (@(posedge smp_clk_i) disable iff (rst_i)
        forwarded_clock_pos_o && $past(forwarded_clock_pos_o) |-> pair_pos_o == '0)
        else $error("pairs active in parallel mode");

    // ==========================================================
    // estimate is bounded; shifts of 20 or more move it one code at a time
    est_clamp_a: assert property (@(posedge smp_clk_i) disable iff (rst_i)
        $signed(offset_estimate_o) <= 8'sh6D && $signed(offset_estimate_o) >= -8'sh6D)
        else $error("offset estimate beyond limit");
    est_step_a: assert property (@(posedge smp_clk_i) disable iff (rst_i)
        $changed(offset_estimate_o) |-> offset_estimate_o == '0
        || offset_estimate_o - $past(offset_estimate_o) inside {8'h01, 8'hFF})
        else $error("offset estimate jumped");

    // ==========================================================
    // a new gain code opens a handshake, which closes in bounded time
    busy_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(gain_code_i) && !cfg_busy_o && !$past(cfg_busy_o) |-> ##[1:2] cfg_busy_o)
        else $error("gain change left busy low");
    busy_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(cfg_busy_o) |-> ##[1:80] !cfg_busy_o) else $error("busy stuck high");
endmodule : agf_formatter_checker

bind agf_formatter agf_formatter_checker u_chk (.clk_i, .rst_i, .smp_clk_i, .gain_code_i,
    .cfg_busy_o, .par_data_o, .pair_pos_o, .pair_neg_o, .forwarded_clock_pos_o,
    .forwarded_clock_neg_o, .offset_estimate_o);

`default_nettype wire

// file: tb/agf_rx_model.sv
// agf_rx_model: capture receiver behind the formatter output pins
`timescale 1ns/1ps
`default_nettype none

module agf_rx_model import agf_pkg::*; #(
    parameter int EYE_NS = 16
) (
    // mode the receiver is set up for
    input wire logic ddr_i,
    // pins from the formatter
    input wire logic fwd_clk_i,
    input wire logic [PAIR_N-1:0] pair_i,
    input wire logic [SAMPLE_W-1:0] par_i,
    // last word recovered
    output logic [SAMPLE_W-1:0] word_o
);
    logic [PAIR_N-1:0] odd_q = '0;
    logic [SAMPLE_W-1:0] ddr_q = '0;
    logic [SAMPLE_W-1:0] par_q = '0;

    // one driver for the recovered word, chosen by the receiver mode
    assign word_o = ddr_i ? ddr_q : par_q;

    // ==========================================================
    // pins flip on the clock edges, so ddr samples a quarter period later
    // parallel uses the forwarded clock: it is inverted and already rises mid-word, so it needs no delay
    always @(posedge fwd_clk_i) begin
        if (ddr_i) begin
            #EYE_NS;
            odd_q = pair_i;
        end else begin
            par_q = par_i;
        end
    end

    // low half closes the word: even bits now, odd bits from the high half
    always @(negedge fwd_clk_i) begin
        if (ddr_i) begin
            #EYE_NS;
            for (int i = 0; i < PAIR_N; i++) begin
                ddr_q[2*i] = pair_i[i];
                ddr_q[2*i+1] = odd_q[i];
            end
        end
    end
endmodule : agf_rx_model

`default_nettype wire

// file: tb/agf_formatter_tb.sv
// agf_formatter_tb: self-checking bench for the formatter and its receiver model
`timescale 1ns/1ps
`default_nettype none

module agf_formatter_tb import agf_pkg::*;;
    // ==========================================================
    // clocks, stimulus and observed pins
    logic clk = 1'b0;
    logic smp_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] gain = 3'h0;
    logic en = 1'b0, hold = 1'b0, strap_sel = 1'b0, ddr = 1'b0, ob = 1'b0;
    logic dd = 1'b0, cd = 1'b0, rx_ddr = 1'b0;
    logic [3:0] tc = 4'hC, swing = 4'h0, sw;
    logic [1:0] strap = 2'h1;
    logic [SAMPLE_W-1:0] conv = '0, par, rx_word;
    logic [PAIR_N-1:0] pp, pn;
    logic fcp, fcn, busy, sw_dd, sw_cd;
    logic [EST_W-1:0] est;
    int err_count = 0, check_count = 0, cyc = 0;

    always #4 clk = ~clk;
    // sampling clock offset so its edges never meet the control clock's
    initial begin
        #1.7;
        forever #32 smp_clk = ~smp_clk;
    end

    agf_formatter DUT (
        .clk_i(clk), .rst_i(rst), .gain_code_i(gain), .offset_loop_enable_i(en),
        .offset_loop_tc_code_i(tc), .offset_loop_hold_i(hold), .use_strap_i(strap_sel),
        .ddr_select_i(ddr), .offset_binary_i(ob), .lvds_swing_i(swing),
        .data_pair_drive_double_i(dd), .clock_pair_drive_double_i(cd), .cfg_busy_o(busy),
        .format_interface_strap_i(strap), .smp_clk_i(smp_clk), .conv_sample_i(conv),
        .par_data_o(par), .pair_pos_o(pp), .pair_neg_o(pn), .forwarded_clock_pos_o(fcp),
        .forwarded_clock_neg_o(fcn), .lvds_swing_o(sw), .data_pair_drive_double_o(sw_dd),
        .clock_pair_drive_double_o(sw_cd), .offset_estimate_o(est)
    );

    agf_rx_model u_rx (.ddr_i(rx_ddr), .fwd_clk_i(fcp), .pair_i(pp), .par_i(par),
        .word_o(rx_word));

    // ==========================================================
    // shared tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out;
        if (err_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    // wait out the crossing, then let the sampling side settle
    // busy is read on the falling edge, away from the edge that launches it
    task automatic apply;
        int n = 0;
        repeat (3) @(negedge clk);
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check("cfg busy", busy, 1'b0);
        repeat (4) @(negedge smp_clk);
    endtask : apply

    // one marked word among zeros must reach the bus exactly at edge 21
    task automatic lat(input logic [13:0] x, input logic [13:0] exp);
        @(negedge smp_clk);
        conv = x;
        @(negedge smp_clk);
        conv = '0;
        repeat (20) @(negedge smp_clk);
        check("par early", par === exp, 1'b0);
        @(negedge smp_clk);
        check("par word", par, exp);
        @(posedge smp_clk);
        check("rx word", rx_word, exp);
    endtask : lat

    task automatic ddr_word(input logic [13:0] x, input logic [13:0] exp);
        logic hit = 1'b0;
        @(negedge smp_clk);
        conv = x;
        @(negedge smp_clk);
        conv = '0;
        repeat (30) begin
            @(negedge smp_clk);
            hit = hit | (rx_word === exp);
        end
        check("ddr word", hit, 1'b1);
    endtask : ddr_word

    // ==========================================================
    // scenarios
    task automatic t_reset;
        check("est", est, 8'h00);
        check("par", par, 14'h0000);
        check("swing", sw, 4'h0);
        check("doubles", {sw_dd, sw_cd}, 2'h0);
    endtask : t_reset

    // input 0x1000 is one in Q12, so the word equals the gain factor
    task automatic t_gain;
        logic [13:0] coef [8] = '{14'h1000, 14'h10F3, 14'h11F4, 14'h1304,
            14'h1425, 14'h1556, 14'h169A, 14'h17F1};
        for (int g = 0; g < 8; g++) begin
            @(negedge clk);
            gain = 3'(g);
            apply();
            lat(14'h1000, coef[g]);
        end
    endtask : t_gain

    task automatic t_over;
        for (int b = 0; b < 2; b++) begin
            @(negedge clk);
            ob = b[0];
            apply();
            lat(14'h1800, b ? 14'h3FFF : 14'h1FFF);
            lat(14'h2800, b ? 14'h0000 : 14'h2000);
        end
        @(negedge clk);
        gain = 3'h0;
        apply();
        lat(14'h0123, 14'h2123);
    endtask : t_over

    task automatic t_strap;
        logic [13:0] w;
        for (int s = 0; s < 4; s++) begin
            @(negedge clk);
            strap_sel = 1'b1;
            strap = 2'(s);
            rx_ddr = (s == 0) || (s == 3);
            apply();
            repeat (25) @(negedge smp_clk);
            w = (s > 1) ? 14'h0AD3 : 14'h2AD3;
            if (rx_ddr) begin
                ddr_word(14'h2AD3, w);
            end else begin
                lat(14'h2AD3, w);
            end
        end
        @(negedge clk);
        strap_sel = 1'b0;
        ddr = 1'b1;
        ob = 1'b0;
        apply();
        repeat (25) @(negedge smp_clk);
        ddr_word(14'h2AD3, 14'h2AD3);
        @(negedge clk);
        ddr = 1'b0;
        rx_ddr = 1'b0;
        apply();
    endtask : t_strap

    task automatic t_drive;
        for (int k = 0; k < 2; k++) begin
            @(negedge clk);
            swing = 4'h5 + 4'(k);
            dd = ~k[0];
            cd = k[0];
            apply();
            check("swing", sw, swing);
            check("drive", {sw_dd, sw_cd}, {dd, cd});
        end
    endtask : t_drive

    // reserved code keeps the reset shift of 20: estimate reaches one after about 130 cycles and is still one at 200
    task automatic t_loop;
        logic [7:0] e;
        @(negedge smp_clk);
        conv = 14'h1FFF;
        @(negedge clk);
        en = 1'b1;
        apply();
        repeat (200) @(negedge smp_clk);
        check("est run", est, 8'h01);
        @(negedge clk);
        hold = 1'b1;
        apply();
        e = est;
        repeat (100) @(negedge smp_clk);
        check("est held", est, e);
        check("par corr", par, 14'h1FFF - 14'(e));
        @(negedge clk);
        en = 1'b0;
        apply();
        check("est off", est, 8'h00);
    endtask : t_loop

    // ==========================================================
    // hang guard and main sequence
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        repeat (32) @(posedge clk);
        t_reset();
        @(negedge clk);
        rst = 1'b0;
        apply();
        t_gain();
        t_over();
        t_strap();
        t_drive();
        t_loop();
        close_out();
    end
endmodule : agf_formatter_tb

`default_nettype wire
